// ---- rtl/csr_receive_shift_register.sv ----
// Serial shift data channel: AHB-Lite register slave and link crossing
//
// Decided for this implementation: the AHB-Lite slave port.
module csr_receive_shift_register
   import csr_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sck,
   input  wire logic        serialIn,
   output logic             serialOut,
   output logic             frameOut
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic          channelEnable;
   logic          transferMode;
   logic          transferBusy;
   logic [7:0]    shiftData;
   logic [7:0]    txData;
   logic          startToggle;
   logic          doneSync;
   logic          doneSeen;
   logic          doneEvent;
   logic          addrPhase;
   logic          wrPending;
   logic [3:0]    wrWord;
   logic          rdShift;
   logic          wrTx;
   logic          wrMode;
   logic          rxStart;
   logic          txStart;
   logic [31:0]   next_hrdata;
   csr_link_req_t linkReq;
   csr_link_rsp_t linkRsp;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [3:0] wordOf(input logic [31:0] addr);
      wordOf = addr[CSR_DEC_MSB:CSR_DEC_LSB];
   endfunction : wordOf

   function automatic logic [7:0] modeImage(input logic en,
                                            input logic md,
                                            input logic bsy);
      logic [7:0] img;
      img                 = 8'h00;
      img[CSR_BIT_ENABLE] = en;
      img[CSR_BIT_TRMODE] = md;
      img[CSR_BIT_BUSY]   = bsy;
      modeImage           = img;
   endfunction : modeImage

   // ************************************************************
   // Bus decode
   // ************************************************************
   assign addrPhase = hsel && hready && (htrans == CSR_HTRANS_NONSEQ);
   assign rdShift   = addrPhase && !hwrite && (wordOf(haddr) == CSR_WORD_SHIFT);
   assign wrTx      = wrPending && (wrWord == CSR_WORD_TXDATA);
   assign wrMode    = wrPending && (wrWord == CSR_WORD_MODE);

   // Starts are refused while disabled or busy; nothing is queued
   assign rxStart   = rdShift && channelEnable && !transferBusy
                      && (transferMode == CSR_MODE_RX);
   assign txStart   = wrTx && channelEnable && !transferBusy
                      && (transferMode == CSR_MODE_TX);

   assign doneEvent = doneSync ^ doneSeen;

   // ************************************************************
   // Address phase capture for writes
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wrPending <= 1'b0;
         wrWord    <= 4'h0;
      end else begin
         wrPending <= addrPhase && hwrite;
         wrWord    <= wordOf(haddr);
      end
   end

   // ************************************************************
   // Read data, registered in the address phase
   // ************************************************************
   always_comb begin
      next_hrdata = 32'h00000000;
      if (addrPhase && !hwrite) begin
         case (wordOf(haddr))
            CSR_WORD_MODE: begin
               next_hrdata[7:0] = modeImage(channelEnable, transferMode, transferBusy);
            end
            CSR_WORD_SHIFT: begin
               // Byte sits in lane 0 whatever hsize asks for
               next_hrdata[7:0] = shiftData;
               // A read right after the enable falls must already see zero
               if (!channelEnable) begin
                  next_hrdata[7:0] = CSR_CLR_SHIFT;
               end
            end
            CSR_WORD_TXDATA: begin
               next_hrdata[7:0] = txData;
            end
            default: begin
               next_hrdata = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hrdata <= 32'h00000000;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp     <= CSR_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= CSR_HRESP_OKAY;
      end
   end

   // ************************************************************
   // Mode register
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         channelEnable <= CSR_RST_ENABLE;
         transferMode  <= CSR_RST_TRMODE;
      end else if (wrMode) begin
         channelEnable <= hwdata[CSR_BIT_ENABLE];
         transferMode  <= hwdata[CSR_BIT_TRMODE];
      end
   end

   // ************************************************************
   // Transmit byte, written by software in either mode while not busy
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         txData <= CSR_RST_TXDATA;
      end else if (wrTx && !transferBusy) begin
         // Held still while busy so the link may sample it across domains
         txData <= hwdata[7:0];
      end
   end

   // ************************************************************
   // Busy flag and start event
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         transferBusy <= 1'b0;
         startToggle  <= 1'b0;
      end else begin
         if (rxStart || txStart) begin
            transferBusy <= 1'b1;
            startToggle  <= ~startToggle;
         end else if (doneEvent) begin
            transferBusy <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Shift data register
   // ************************************************************
   // Bus writes never reach this register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shiftData <= CSR_RST_SHIFT;
      end else if (!channelEnable) begin
         shiftData <= CSR_CLR_SHIFT;
      end else if (doneEvent) begin
         shiftData <= linkRsp.rxByte;
      end
   end

   // ************************************************************
   // Clock domain crossing
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         doneSeen <= 1'b0;
      end else begin
         doneSeen <= doneSync;
      end
   end

   csr_bit_sync u_done_sync (
      .clk  (core_clk),
      .din  (linkRsp.doneToggle),
      .dout (doneSync)
   );

   always_comb begin
      linkReq.startToggle = startToggle;
      // Receive mode shifts the last received byte back out
      linkReq.txByte      = (transferMode == CSR_MODE_TX) ? txData : shiftData;
   end

   csr_link_shift u_link (
      .sck       (sck),
      .srst      (srst),
      .linkReq   (linkReq),
      .linkRsp   (linkRsp),
      .serialIn  (serialIn),
      .serialOut (serialOut),
      .frameOut  (frameOut)
   );

endmodule : csr_receive_shift_register

// ---- rtl/csr_pkg.sv ----
// Shared constants and types for the clocked serial shift data channel
package csr_pkg;

   // ************************************************************
   // Register indices and byte addresses
   // ************************************************************
   localparam logic [31:0] CSR_IDX_MODE   = 32'hfffff900;
   localparam logic [31:0] CSR_IDX_SHIFT  = 32'hfffff902;
   localparam logic [31:0] CSR_IDX_TXDATA = 32'hfffff904;
   // Only the low index bits are decoded; byte address is four times the index
   localparam int          CSR_DEC_LSB    = 2;
   localparam int          CSR_DEC_MSB    = 5;
   localparam logic [3:0]  CSR_WORD_MODE   = CSR_IDX_MODE[3:0];
   localparam logic [3:0]  CSR_WORD_SHIFT  = CSR_IDX_SHIFT[3:0];
   localparam logic [3:0]  CSR_WORD_TXDATA = CSR_IDX_TXDATA[3:0];

   // ************************************************************
   // Mode register fields and reset values
   // ************************************************************
   localparam int          CSR_BIT_ENABLE  = 7;
   localparam int          CSR_BIT_TRMODE  = 6;
   localparam int          CSR_BIT_BUSY    = 0;
   localparam logic        CSR_RST_ENABLE  = 1'b0;
   localparam logic        CSR_RST_TRMODE  = 1'b0;
   localparam logic [7:0]  CSR_RST_SHIFT   = 8'h00;
   localparam logic [7:0]  CSR_RST_TXDATA  = 8'h00;
   localparam logic [7:0]  CSR_CLR_SHIFT   = 8'h00;
   localparam logic        CSR_MODE_RX     = 1'b0;
   localparam logic        CSR_MODE_TX     = 1'b1;

   // ************************************************************
   // Link framing
   // ************************************************************
   localparam int          CSR_BYTE_BITS   = 8;
   localparam logic [2:0]  CSR_LAST_BIT    = 3'h7;

   // ************************************************************
   // AHB-Lite encodings
   // ************************************************************
   localparam logic [1:0]  CSR_HTRANS_NONSEQ = 2'h2;
   localparam logic        CSR_HRESP_OKAY    = 1'b0;

   typedef enum logic [1:0] {
      CSR_LK_IDLE  = 2'h1,
      CSR_LK_SHIFT = 2'h2
   } csr_link_state_t;

   // Core to link: start event as a toggle plus the byte to send
   typedef struct packed {
      logic       startToggle;
      logic [7:0] txByte;
   } csr_link_req_t;

   // Link to core: completion toggle plus the byte received
   typedef struct packed {
      logic       doneToggle;
      logic [7:0] rxByte;
   } csr_link_rsp_t;

endpackage : csr_pkg

// ---- rtl/csr_bit_sync.sv ----
// Two flip-flop level synchroniser
module csr_bit_sync
   import csr_pkg::*;
(
   input  wire logic clk,
   input  wire logic din,
   output logic      dout
);

   logic stage1;

   // ************************************************************
   // First stage is read only by the second stage
   // ************************************************************
   always_ff @(posedge clk) begin
      stage1 <= din;
      dout   <= stage1;
   end

endmodule : csr_bit_sync

// ---- rtl/csr_link_shift.sv ----
// Link-clock side of the channel: shifts one byte out and one byte in
module csr_link_shift
   import csr_pkg::*;
(
   input  wire logic          sck,
   input  wire logic          srst,
   input  wire csr_link_req_t linkReq,
   output csr_link_rsp_t      linkRsp,
   input  wire logic          serialIn,
   output logic              serialOut,
   output logic              frameOut
);

   csr_link_state_t state;
   logic            linkRst;
   logic            startSync;
   logic            startSeen;
   logic [2:0]      bitCount;
   logic [7:0]      rxShift;

   csr_bit_sync u_rst_sync (
      .clk  (sck),
      .din  (srst),
      .dout (linkRst)
   );

   csr_bit_sync u_start_sync (
      .clk  (sck),
      .din  (linkReq.startToggle),
      .dout (startSync)
   );

   // ************************************************************
   // Frame control and capture on the rising edge
   // ************************************************************
   always_ff @(posedge sck) begin
      if (linkRst) begin
         state      <= CSR_LK_IDLE;
         startSeen  <= 1'b0;
         bitCount   <= 3'h0;
         rxShift    <= 8'h00;
         linkRsp    <= '0;
      end else begin
         case (state)
            CSR_LK_IDLE: begin
               if (startSync != startSeen) begin
                  startSeen <= startSync;
                  bitCount  <= 3'h0;
                  state     <= CSR_LK_SHIFT;
               end
            end
            CSR_LK_SHIFT: begin
               rxShift  <= {rxShift[6:0], serialIn};
               bitCount <= bitCount + 3'h1;
               if (bitCount == CSR_LAST_BIT) begin
                  // Byte is stable before the toggle is seen by the core
                  linkRsp.rxByte     <= {rxShift[6:0], serialIn};
                  linkRsp.doneToggle <= ~linkRsp.doneToggle;
                  state              <= CSR_LK_IDLE;
               end
            end
            default: begin
               state <= CSR_LK_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Launch on the falling edge, most significant bit first
   // ************************************************************
   always_ff @(negedge sck) begin
      if (linkRst) begin
         serialOut <= 1'b0;
         frameOut  <= 1'b0;
      end else begin
         frameOut  <= (state == CSR_LK_SHIFT);
         if (state == CSR_LK_SHIFT) begin
            serialOut <= linkReq.txByte[CSR_LAST_BIT - bitCount];
         end else begin
            serialOut <= 1'b0;
         end
      end
   end

endmodule : csr_link_shift

// ---- testbench/csr_receive_shift_register_monitor.sv ----
// Port checker for the serial shift data channel
module csr_receive_shift_register_monitor
   import csr_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sck,
   input wire logic        serialIn,
   input wire logic        serialOut,
   input wire logic        frameOut
);
   logic       apValid;
   logic       apWr;
   logic [3:0] apWord;
   logic       shEn;
   logic       shMd;
   logic       apEn;
   wire logic  take = hsel && hready && htrans == CSR_HTRANS_NONSEQ;
   wire logic  rdShiftDp = apValid && !apWr && apWord == CSR_WORD_SHIFT;
   wire logic  rdShiftAp = take && !hwrite && haddr[CSR_DEC_MSB:CSR_DEC_LSB] == CSR_WORD_SHIFT;

   always_ff @(posedge core_clk) begin
      apValid <= !srst && take;
      apWr    <= hwrite;
      apWord  <= haddr[CSR_DEC_MSB:CSR_DEC_LSB];
      // Enable as it stood at the address phase of the read
      apEn    <= shEn;
   end

   // Shadow of the mode bits, so reads can be judged without peeking inside
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shEn <= CSR_RST_ENABLE;
         shMd <= CSR_RST_TRMODE;
      end else if (apValid && apWr && apWord == CSR_WORD_MODE) begin
         shEn <= hwdata[CSR_BIT_ENABLE];
         shMd <= hwdata[CSR_BIT_TRMODE];
      end
   end

   chk_bus_okay: assert property (@(posedge core_clk) disable iff (srst)
      hreadyout && hresp == CSR_HRESP_OKAY) else $error("bus answer not ready or not okay");
   chk_rdata_idle: assert property (@(posedge core_clk) disable iff (srst)
      !apValid || apWr |-> hrdata == 32'h0) else $error("read data outside a read");
   chk_upper_zero: assert property (@(posedge core_clk) disable iff (srst)
      apValid && !apWr |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
   chk_disabled_zero: assert property (@(posedge core_clk) disable iff (srst)
      rdShiftDp && !apEn |-> hrdata[7:0] == CSR_CLR_SHIFT) else $error("shift data not cleared");
   chk_read_starts: assert property (@(posedge core_clk) disable iff (srst)
      rdShiftAp && shEn && shMd == CSR_MODE_RX && !frameOut |-> ##[1:60] frameOut)
      else $error("read did not start a frame");
   chk_frame_len: assert property (@(posedge sck) disable iff (srst)
      $rose(frameOut) |-> frameOut [*8] ##1 !frameOut) else $error("frame not eight bits");
   chk_idle_quiet: assert property (@(posedge sck) disable iff (srst)
      !frameOut |-> !serialOut) else $error("serial out active outside frame");

   cov_rx_start: cover property (@(posedge core_clk) rdShiftAp && shEn && shMd == CSR_MODE_RX);
   cov_frame: cover property (@(posedge sck) $rose(frameOut));
   cov_disabled: cover property (@(posedge core_clk) rdShiftDp && !apEn);
endmodule : csr_receive_shift_register_monitor

bind csr_receive_shift_register csr_receive_shift_register_monitor u_mon (
   .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .sck(sck), .serialIn(serialIn),
   .serialOut(serialOut), .frameOut(frameOut));

// ---- testbench/csr_serial_partner.sv ----
// Behavioural serial partner on the far side of the link
module csr_serial_partner (
   input wire logic       sck,
   input wire logic       frameOut,
   input wire logic       serialOut,
   input wire logic [7:0] sendByte,
   output logic           serialIn,
   output logic [7:0]     gotByte
);
   timeunit 1ns;
   timeprecision 100ps;
   int idx = 0;
   initial serialIn = 1'b0;
   initial gotByte = 8'h00;
   // Outside frames the line toggles so a stale bit is never mistaken for data
   always @(negedge sck) begin
      #1;
      if (frameOut) begin
         serialIn = sendByte[7 - idx];
         idx++;
      end else begin
         idx = 0;
         serialIn = ~serialIn;
      end
   end
   always @(posedge sck) begin
      if (frameOut) gotByte <= {gotByte[6:0], serialOut};
   end
endmodule : csr_serial_partner

// ---- testbench/test_csi_receive_shift_register.sv ----
// Self-checking bench for the serial shift data channel
module test_csi_receive_shift_register
   import csr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] A_MODE  = 32'(CSR_WORD_MODE) << 2;
   localparam logic [31:0] A_SHIFT = 32'(CSR_WORD_SHIFT) << 2;
   localparam logic [31:0] A_TX    = 32'(CSR_WORD_TXDATA) << 2;
   localparam logic [31:0] A_NONE  = 32'h0000003c;
   localparam logic [31:0] EN      = 32'h1 << CSR_BIT_ENABLE;
   localparam logic [31:0] TXM     = 32'h1 << CSR_BIT_TRMODE;
   logic core_clk = 0, srst = 1, hsel = 0, hwrite = 0, sck = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [7:0]  sendByte = 8'h00, gotByte;
   logic        hreadyout, hresp, serialIn, serialOut, frameOut;
   int          n_errors = 0, total_checks = 0;

   always #5 core_clk = ~core_clk;
   initial begin
      #13;
      forever #32 sck = ~sck;
   end

   csr_receive_shift_register dut (.core_clk(core_clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sck(sck), .serialIn(serialIn), .serialOut(serialOut), .frameOut(frameOut));
   csr_serial_partner partner (.sck(sck), .frameOut(frameOut), .serialOut(serialOut),
      .sendByte(sendByte), .serialIn(serialIn), .gotByte(gotByte));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= CSR_HTRANS_NONSEQ;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk

   // Software keeps off the shift data until the busy flag reads clear
   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         bus(1'b0, A_MODE, 32'h0);
         if (rd[CSR_BIT_BUSY] === 1'b0) return;
      end
      chk(32'(rd[CSR_BIT_BUSY]), 32'h0);
   endtask : wait_idle

   task automatic t_reset;
      rd_chk(A_SHIFT, 32'(CSR_RST_SHIFT));
      rd_chk(A_NONE, 32'h0);
   endtask : t_reset

   task automatic t_rx;
      bus(1'b1, A_MODE, EN);
      sendByte <= 8'ha5;
      rd_chk(A_SHIFT, 32'h0);
      rd_chk(A_MODE, EN | 32'h1);
      wait_idle();
      chk(gotByte, 8'h00);
      sendByte <= 8'h3c;
      rd_chk(A_SHIFT, 32'ha5);
      wait_idle();
      chk(gotByte, 8'ha5);
   endtask : t_rx

   task automatic t_write_ignored;
      bus(1'b1, A_SHIFT, 32'hff);
      rd_chk(A_MODE, EN);
      rd_chk(A_SHIFT, 32'h3c);
      wait_idle();
   endtask : t_write_ignored

   task automatic t_disable;
      bus(1'b1, A_MODE, 32'h0);
      rd_chk(A_SHIFT, 32'(CSR_CLR_SHIFT));
      repeat (100) @(posedge core_clk);
      rd_chk(A_MODE, 32'h0);
   endtask : t_disable

   task automatic t_tx;
      bus(1'b1, A_MODE, EN | TXM);
      sendByte <= 8'h69;
      bus(1'b1, A_TX, 32'h96);
      wait_idle();
      chk(gotByte, 8'h96);
      rd_chk(A_TX, 32'h96);
      rd_chk(A_SHIFT, 32'h69);
      rd_chk(A_MODE, EN | TXM);
   endtask : t_tx

   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // Reset outlasts several link clocks so the link side sees it too
   initial begin
      repeat (30) @(posedge core_clk);
      srst <= 1'b0;
      repeat (40) @(posedge core_clk);
      t_reset();
      t_rx();
      t_write_ignored();
      t_disable();
      t_tx();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      end_sim();
   end
endmodule : test_csi_receive_shift_register
